// ---- design/dmcd_regs.svh ----
// Command codes, reset values and timing constants of the display mode command decoder
`ifndef DMCD_REGS_SVH
`define DMCD_REGS_SVH

// Command bytes, written with the data/command select low
`define DMCD_CMD_SOFT_RESET          8'h01
`define DMCD_CMD_SLEEP_IN            8'h10
`define DMCD_CMD_LEAVE_SLEEP         8'h11
`define DMCD_CMD_PARTIAL_NORMAL_OFF  8'h12
`define DMCD_CMD_NORMAL_DISPLAY      8'h13
`define DMCD_CMD_INVERSION_DISABLE   8'h20
`define DMCD_CMD_INVERSION_ENABLE    8'h21
`define DMCD_CMD_BLANK_OUTPUT        8'h28
`define DMCD_CMD_SHOW_OUTPUT         8'h29

// Reset values of the mode state and of the synchronised pins
`define DMCD_RST_NORMAL_OFF          1'b0
`define DMCD_RST_INVERSION           1'b0
`define DMCD_RST_DISPLAY_ON          1'b0
`define DMCD_PIN_IDLE                11'h700

// Timing: clock period and start-up phase lengths
`define DMCD_CLK_PERIOD_NS           8
`define DMCD_OSC_START_US            100
`define DMCD_DCDC_START_US           1000
`define DMCD_OFFSET_CHARGE_US        1000
`define DMCD_FRAME_PERIOD_US         16667
`define DMCD_AUTO_BLANK_FRAMES       2

// Least time in microseconds to whole clock cycles, rounded up
`define DMCD_US_TO_CYCLES(us) ((((us) * 1000) + `DMCD_CLK_PERIOD_NS - 1) / `DMCD_CLK_PERIOD_NS)

`endif

// ---- design/dmcd_pkg.sv ----
// Types shared by the display mode command decoder modules
package dmcd_pkg;

    // Power sequence states, one-hot
    typedef enum logic [5:0] {
        PWR_SLEEP_IN      = 6'b000001,
        PWR_OSC_START     = 6'b000010,
        PWR_DCDC_START    = 6'b000100,
        PWR_OFFSET_CHARGE = 6'b001000,
        PWR_AUTO_BLANK    = 6'b010000,
        PWR_SLEEP_OUT     = 6'b100000
    } dmcd_power_state_t;

    // One command byte from the host
    typedef logic [7:0] dmcd_cmd_byte_t;

endpackage : dmcd_pkg

// ---- design/dmcd_cmd_if.sv ----
// Captured command bytes passed from the pin capture to the decoder
`timescale 1ns/1ps
interface dmcd_cmd_if;
    logic                    cmdValid;
    dmcd_pkg::dmcd_cmd_byte_t cmdByte;

    modport producer (output cmdValid, output cmdByte);
    modport consumer (input cmdValid, input cmdByte);
endinterface : dmcd_cmd_if

// ---- design/dmcd_cmd_capture.sv ----
// Synchronises the host command pins and captures command bytes on write strobe rising edges
`timescale 1ns/1ps
`include "dmcd_regs.svh"
module dmcd_cmd_capture
    import dmcd_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Host pins
    input  wire logic       writeStrobeN,
    input  wire logic       readStrobeN,
    input  wire logic       dataCommandSelect,
    input  wire logic [7:0] dataBus,
    // Captured commands
    dmcd_cmd_if.producer    cmdPort
);

    logic [10:0]    pinMeta_r;
    logic [10:0]    pinSync_r;
    logic           wrPrev_r;
    logic           cmdValid_r;
    dmcd_cmd_byte_t cmdByte_r;

    wire  [10:0]    pinIn  = {readStrobeN, dataCommandSelect, writeStrobeN, dataBus};
    wire            wrSync = pinSync_r[8];
    wire            dcSync = pinSync_r[9];
    wire            rdSync = pinSync_r[10];
    wire            wrRise = wrSync & ~wrPrev_r;

    // Two-stage synchroniser; only the second stage feeds logic
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pinMeta_r <= `DMCD_PIN_IDLE;
            pinSync_r <= `DMCD_PIN_IDLE;
            wrPrev_r  <= 1'b1;
        end else begin
            pinMeta_r <= pinIn;
            pinSync_r <= pinMeta_r;
            wrPrev_r  <= wrSync;
        end
    end

    // Byte taken on every strobe rising edge; flagged valid only while select is low and read strobe is high
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cmdValid_r <= 1'b0;
            cmdByte_r  <= 8'h00;
        end else begin
            cmdValid_r <= wrRise & ~dcSync & rdSync;
            if (wrRise) begin
                cmdByte_r <= pinSync_r[7:0];
            end
        end
    end

    assign cmdPort.cmdValid = cmdValid_r;
    assign cmdPort.cmdByte  = cmdByte_r;

endmodule : dmcd_cmd_capture

// ---- design/dmcd_mode_decoder.sv ----
// Display mode command decoder: leave-sleep sequence, normal-off, inversion and display off
//
// Functional notes
// - Leave-sleep starts oscillator, then DC/DC converter, then panel offset charge, in order.
// - After supply start-up, two blank frames, then memory contents per current settings.
// - Automatic blank frames happen whatever the display on/off state or mode commands; only sleep-in 10h or soft reset 01h aborts them.
// - Byte 12h enters normal-off mode; idle settings apply, idle mode not entered.
// - Only normal-on byte 13h or soft reset byte 01h leaves normal-off mode, back to normal display.
// - Normal-off command is a no-operation while normal-off is already active.
// - Normal-on command is a no-operation while normal display is already active.
// - One mode bit: normal display on means exactly normal-off off.
// - Byte 20h leaves inversion; pixels shown without inversion.
// - Inversion-off command ignored when inversion is already off.
// - Byte 21h enters inversion; each frame memory pixel shown inverted.
// - Inversion-on command ignored when inversion is already on.
// - Byte 28h disables frame memory output and inserts a blank page.
// - Display-off changes no frame memory and no other mode or status.
// - Only display-on byte 29h leaves display-off mode.
// - Display-off command ignored when display-off is already active.
// - Sleep-out left only by byte 10h or soft reset byte 01h; repeated leave-sleep ignored.
`timescale 1ns/1ps
`include "dmcd_regs.svh"
module dmcd_mode_decoder
    import dmcd_pkg::*;
#(
    parameter int OSC_START_CYCLES    = `DMCD_US_TO_CYCLES(`DMCD_OSC_START_US),
    parameter int DCDC_START_CYCLES   = `DMCD_US_TO_CYCLES(`DMCD_DCDC_START_US),
    parameter int OFFSET_CHARGE_CYCLES = `DMCD_US_TO_CYCLES(`DMCD_OFFSET_CHARGE_US),
    parameter int FRAME_CYCLES        = `DMCD_US_TO_CYCLES(`DMCD_FRAME_PERIOD_US),
    parameter int AUTO_BLANK_FRAMES   = `DMCD_AUTO_BLANK_FRAMES,
    parameter int CNT_W               = 24
)
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,

    // Host command pins
    input  wire logic       writeStrobeN,
    input  wire logic       readStrobeN,
    input  wire logic       dataCommandSelect,
    input  wire logic [7:0] dataBus,

    // Supply start-up controls
    output logic            oscEnable,
    output logic            dcdcEnable,
    output logic            offsetChargeEnable,

    // Panel output control
    output logic            sleepOut,
    output logic            autoBlankActive,
    output logic            frameStart,
    output logic            panelShowMemory,

    // Mode status
    output logic            normalMode,
    output logic            partialNormalOff,
    output logic            idleSettingsApply,
    output logic            inversionOn,
    output logic            displayOn,
    output logic            cmdIgnored
);

    // Last count of each timed phase
    localparam logic [CNT_W-1:0] OSC_LAST    = CNT_W'(OSC_START_CYCLES - 1);
    localparam logic [CNT_W-1:0] DCDC_LAST   = CNT_W'(DCDC_START_CYCLES - 1);
    localparam logic [CNT_W-1:0] CHARGE_LAST = CNT_W'(OFFSET_CHARGE_CYCLES - 1);
    localparam logic [CNT_W-1:0] FRAME_LAST  = CNT_W'(FRAME_CYCLES - 1);
    localparam logic [3:0]       BLANK_LAST  = 4'(AUTO_BLANK_FRAMES - 1);

    // Command carrier between capture and decoder
    dmcd_cmd_if cmdBus ();

    // Pin synchroniser and byte capture
    // Asynchronous pins are synchronised there
    dmcd_cmd_capture u_capture (
        .ref_clk           (ref_clk),
        .rst_n             (rst_n),
        .writeStrobeN      (writeStrobeN),
        .readStrobeN       (readStrobeN),
        .dataCommandSelect (dataCommandSelect),
        .dataBus           (dataBus),
        .cmdPort           (cmdBus.producer)
    );

    // True when a valid command carries the given code
    function automatic logic isCmd(
        input logic           valid,
        input dmcd_cmd_byte_t byteIn,
        input dmcd_cmd_byte_t code
    );
        isCmd = valid && (byteIn == code);
    endfunction : isCmd

    // True when a counter has reached its last count
    // At or past, so an upset count still ends
    function automatic logic cntDone(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] last
    );
        cntDone = (cnt >= last);
    endfunction : cntDone

    // State registers
    dmcd_power_state_t power_r;
    dmcd_power_state_t powerNxt;
    logic [CNT_W-1:0]  seqCnt_r;
    logic [CNT_W-1:0]  seqCntNxt;
    logic [CNT_W-1:0]  frameCnt_r;
    logic [CNT_W-1:0]  frameCntNxt;
    logic [3:0]        blankCnt_r;
    logic [3:0]        blankCntNxt;
    logic              normalOff_r;
    logic              normalOffNxt;
    logic              inversion_r;
    logic              inversionNxt;
    logic              show_output_cmd_r;
    logic              dispOnNxt;
    logic              ignoredNxt;

    // Command decode
    wire cmdValid          = cmdBus.cmdValid;
    wire dmcd_cmd_byte_t cb = cmdBus.cmdByte;
    wire softResetCmd         = isCmd(cmdValid, cb, `DMCD_CMD_SOFT_RESET);
    wire sleepInCmd           = isCmd(cmdValid, cb, `DMCD_CMD_SLEEP_IN);
    wire leaveSleepCmd        = isCmd(cmdValid, cb, `DMCD_CMD_LEAVE_SLEEP);
    wire partialNormalOffCmd  = isCmd(cmdValid, cb, `DMCD_CMD_PARTIAL_NORMAL_OFF);
    wire normalDisplayCmd     = isCmd(cmdValid, cb, `DMCD_CMD_NORMAL_DISPLAY);
    wire inversionDisableCmd  = isCmd(cmdValid, cb, `DMCD_CMD_INVERSION_DISABLE);
    wire inversionEnableCmd   = isCmd(cmdValid, cb, `DMCD_CMD_INVERSION_ENABLE);
    wire blankOutputCmd       = isCmd(cmdValid, cb, `DMCD_CMD_BLANK_OUTPUT);
    wire showOutputCmd        = isCmd(cmdValid, cb, `DMCD_CMD_SHOW_OUTPUT);

    // Frame timing runs whenever the oscillator is up
    wire oscRunning = (power_r != PWR_SLEEP_IN);
    wire frameTick  = oscRunning && cntDone(frameCnt_r, FRAME_LAST);

    // Sleep-exit sequence and sleep entry
    always_comb begin
        powerNxt    = power_r;
        seqCntNxt   = seqCnt_r + 1'b1;
        blankCntNxt = blankCnt_r;
        frameCntNxt = frameTick ? '0 : frameCnt_r + 1'b1;
        case (power_r)
            PWR_SLEEP_IN: begin
                seqCntNxt   = '0;
                frameCntNxt = '0;
                if (leaveSleepCmd) begin
                    powerNxt = PWR_OSC_START;
                end
            end
            PWR_OSC_START: begin
                if (cntDone(seqCnt_r, OSC_LAST)) begin
                    powerNxt  = PWR_DCDC_START;
                    seqCntNxt = '0;
                end
            end
            PWR_DCDC_START: begin
                if (cntDone(seqCnt_r, DCDC_LAST)) begin
                    powerNxt  = PWR_OFFSET_CHARGE;
                    seqCntNxt = '0;
                end
            end
            PWR_OFFSET_CHARGE: begin
                if (cntDone(seqCnt_r, CHARGE_LAST)) begin
                    powerNxt    = PWR_AUTO_BLANK;
                    seqCntNxt   = '0;
                    blankCntNxt = '0;
                    frameCntNxt = '0; // Blank frames start whole
                end
            end
            PWR_AUTO_BLANK: begin
                seqCntNxt = '0;
                if (frameTick) begin
                    if (blankCnt_r >= BLANK_LAST) begin
                        powerNxt = PWR_SLEEP_OUT;
                    end else begin
                        blankCntNxt = blankCnt_r + 1'b1;
                    end
                end
            end
            PWR_SLEEP_OUT: begin
                seqCntNxt = '0;
            end
            default: begin
                powerNxt  = PWR_SLEEP_IN;
                seqCntNxt = '0;
            end
        endcase
        // Sleep entry aborts or ends any waking state
        // Last, so it beats any phase step
        if (sleepInCmd || softResetCmd) begin
            powerNxt    = PWR_SLEEP_IN;
            seqCntNxt   = '0;
            frameCntNxt = '0;
            blankCntNxt = '0;
        end
    end

    // Display mode state: one bit each, commands that change nothing are no-ops
    always_comb begin
        normalOffNxt = normalOff_r;
        inversionNxt = inversion_r;
        dispOnNxt    = show_output_cmd_r;
        if (partialNormalOffCmd) begin
            normalOffNxt = 1'b1;
        end
        if (normalDisplayCmd) begin
            normalOffNxt = 1'b0;
        end
        if (inversionDisableCmd) begin
            inversionNxt = 1'b0;
        end
        if (inversionEnableCmd) begin
            inversionNxt = 1'b1;
        end
        if (blankOutputCmd) begin
            dispOnNxt = 1'b0;
        end
        if (showOutputCmd) begin
            dispOnNxt = 1'b1;
        end
        if (softResetCmd) begin
            normalOffNxt = `DMCD_RST_NORMAL_OFF;
            inversionNxt = `DMCD_RST_INVERSION;
            dispOnNxt    = `DMCD_RST_DISPLAY_ON;
        end
    end

    // Flags a command that found its target state already in place
    always_comb begin
        ignoredNxt = 1'b0;
        if (leaveSleepCmd && (power_r != PWR_SLEEP_IN)) begin
            ignoredNxt = 1'b1;
        end
        if (sleepInCmd && (power_r == PWR_SLEEP_IN)) begin
            ignoredNxt = 1'b1;
        end
        if (partialNormalOffCmd && normalOff_r) begin
            ignoredNxt = 1'b1;
        end
        if (normalDisplayCmd && !normalOff_r) begin
            ignoredNxt = 1'b1;
        end
        if (inversionDisableCmd && !inversion_r) begin
            ignoredNxt = 1'b1;
        end
        if (inversionEnableCmd && inversion_r) begin
            ignoredNxt = 1'b1;
        end
        if (blankOutputCmd && !show_output_cmd_r) begin
            ignoredNxt = 1'b1;
        end
        if (showOutputCmd && show_output_cmd_r) begin
            ignoredNxt = 1'b1;
        end
    end

    // Sequence state and counters
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            power_r    <= PWR_SLEEP_IN;
            seqCnt_r   <= '0;
            frameCnt_r <= '0;
            blankCnt_r <= '0;
        end else begin
            power_r    <= powerNxt;
            seqCnt_r   <= seqCntNxt;
            frameCnt_r <= frameCntNxt;
            blankCnt_r <= blankCntNxt;
        end
    end

    // Mode bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            normalOff_r <= `DMCD_RST_NORMAL_OFF;
            inversion_r <= `DMCD_RST_INVERSION;
            show_output_cmd_r    <= `DMCD_RST_DISPLAY_ON;
        end else begin
            normalOff_r <= normalOffNxt;
            inversion_r <= inversionNxt;
            show_output_cmd_r    <= dispOnNxt;
        end
    end

    // Supply enables follow the sequence and stay on until sleep-in or soft reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            oscEnable          <= 1'b0;
            dcdcEnable         <= 1'b0;
            offsetChargeEnable <= 1'b0;
        end else begin
            oscEnable          <= (powerNxt != PWR_SLEEP_IN);
            dcdcEnable         <= (powerNxt inside {PWR_DCDC_START, PWR_OFFSET_CHARGE,
                                                    PWR_AUTO_BLANK, PWR_SLEEP_OUT});
            offsetChargeEnable <= (powerNxt inside {PWR_OFFSET_CHARGE, PWR_AUTO_BLANK,
                                                    PWR_SLEEP_OUT});
        end
    end

    // Panel output: blank frames override the display on/off bit
    // Memory shown only after the blank frames
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sleepOut        <= 1'b0;
            autoBlankActive <= 1'b0;
            frameStart      <= 1'b0;
            panelShowMemory <= 1'b0;
        end else begin
            sleepOut        <= (powerNxt == PWR_SLEEP_OUT);
            autoBlankActive <= (powerNxt == PWR_AUTO_BLANK);
            frameStart      <= frameTick;
            panelShowMemory <= (powerNxt == PWR_SLEEP_OUT) && dispOnNxt;
        end
    end

    // Mode status outputs
    // Driven from next values, in step with the mode bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            normalMode        <= ~`DMCD_RST_NORMAL_OFF;
            partialNormalOff  <= `DMCD_RST_NORMAL_OFF;
            idleSettingsApply <= `DMCD_RST_NORMAL_OFF;
            inversionOn       <= `DMCD_RST_INVERSION;
            displayOn         <= `DMCD_RST_DISPLAY_ON;
            cmdIgnored        <= 1'b0;
        end else begin
            normalMode        <= ~normalOffNxt;
            partialNormalOff  <= normalOffNxt;
            idleSettingsApply <= normalOffNxt;
            inversionOn       <= inversionNxt;
            displayOn         <= dispOnNxt;
            cmdIgnored        <= ignoredNxt;
        end
    end

endmodule : dmcd_mode_decoder

// ---- tb/dmcd_mode_assertions.sv ----
// Concurrent checks on the ports of the display mode command decoder
`timescale 1ns/1ps
module dmcd_mode_assertions (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // Host command pins
    input wire logic       writeStrobeN,
    input wire logic       readStrobeN,
    input wire logic       dataCommandSelect,
    input wire logic [7:0] dataBus,
    // Supply and panel control
    input wire logic       oscEnable,
    input wire logic       dcdcEnable,
    input wire logic       offsetChargeEnable,
    input wire logic       sleepOut,
    input wire logic       autoBlankActive,
    input wire logic       frameStart,
    input wire logic       panelShowMemory,
    // Mode status
    input wire logic       normalMode,
    input wire logic       partialNormalOff,
    input wire logic       idleSettingsApply,
    input wire logic       inversionOn,
    input wire logic       displayOn,
    input wire logic       cmdIgnored
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Mode bits and start-up phases
    property p_mode_exclusive; normalMode != partialNormalOff; endproperty
    property p_idle_follow; idleSettingsApply == partialNormalOff; endproperty
    property p_osc_first; $rose(oscEnable) |-> !dcdcEnable[*3] ##[1:8] (dcdcEnable || !oscEnable); endproperty
    property p_phase_order; offsetChargeEnable |-> dcdcEnable && oscEnable; endproperty
    property p_blank_frames; $rose(autoBlankActive) |-> autoBlankActive[*8]; endproperty
    property p_blank_end; $rose(sleepOut) |-> $past(autoBlankActive) && offsetChargeEnable; endproperty
    property p_blank_hides; autoBlankActive |-> !panelShowMemory; endproperty
    property p_panel_src; panelShowMemory |-> sleepOut && displayOn; endproperty
    // Mode changes tied to the command byte that caused them; ignored-command pulse length and effect
    property p_inv_on; $rose(inversionOn) |-> $past(dataBus, 5) == 8'h21; endproperty
    property p_noff_on; $rose(partialNormalOff) |-> $past(dataBus, 5) == 8'h12; endproperty
    property p_disp_off; $fell(displayOn) |-> $past(dataBus, 5) inside {8'h28, 8'h01}; endproperty
    property p_disp_on; $rose(displayOn) |-> $past(dataBus, 5) == 8'h29; endproperty
    property p_ign_pulse; cmdIgnored |=> !cmdIgnored; endproperty
    property p_ign_keeps;
        cmdIgnored |-> $stable(inversionOn) && $stable(partialNormalOff) && $stable(displayOn);
    endproperty

    a_mode_exclusive: assert property (p_mode_exclusive) else $error("normal and normal-off both set");
    a_idle_follow:    assert property (p_idle_follow) else $error("idle settings differ from mode");
    a_osc_first:      assert property (p_osc_first) else $error("converter start out of time");
    a_phase_order:    assert property (p_phase_order) else $error("offset charge before supplies");
    a_blank_frames:   assert property (p_blank_frames) else $error("blank frames cut short");
    a_blank_end:      assert property (p_blank_end) else $error("awake without blank frames");
    a_blank_hides:    assert property (p_blank_hides) else $error("memory shown in blank frames");
    a_panel_src:      assert property (p_panel_src) else $error("memory shown while off");
    a_inv_on:         assert property (p_inv_on) else $error("inversion set without command");
    a_noff_on:        assert property (p_noff_on) else $error("normal-off set without command");
    a_disp_off:       assert property (p_disp_off) else $error("display cleared without command");
    a_disp_on:        assert property (p_disp_on) else $error("display set without command");
    a_ign_pulse:      assert property (p_ign_pulse) else $error("ignored pulse too long");
    a_ign_keeps:      assert property (p_ign_keeps) else $error("ignored command changed mode");

    // Main scenarios reached
    c_wake: cover property ($rose(sleepOut));
    c_ign:  cover property (cmdIgnored);
    c_inv:  cover property ($rose(inversionOn));
    c_off:  cover property ($fell(displayOn));
endmodule : dmcd_mode_assertions

// ---- tb/dmcd_host_model.sv ----
// Behavioural host that writes command bytes on the decoder pins
`timescale 1ns/1ps
module dmcd_host_model #(
    parameter int LEAVE_WAIT = 10
) (
    // Clock
    input  wire logic       ref_clk,
    // Command pins
    output logic            writeStrobeN,
    output logic            readStrobeN,
    output logic            dataCommandSelect,
    output logic [7:0]      dataBus
);
    // Idle pins at time zero
    initial begin
        writeStrobeN = 1'b1;
        readStrobeN = 1'b1;
        dataCommandSelect = 1'b0;
        dataBus = 8'h00;
    end

    // One byte per strobe, held well around the rising edge
    task automatic send(input logic [7:0] b, input logic dc, input logic rd);
        @(posedge ref_clk);
        #1;
        dataBus = b;
        dataCommandSelect = dc;
        readStrobeN = rd;
        writeStrobeN = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        writeStrobeN = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        dataBus = ~b; // Released bus never keeps the last byte
        readStrobeN = 1'b1;
        if (b == 8'h11 && !dc) repeat (LEAVE_WAIT) @(posedge ref_clk);
    endtask : send
endmodule : dmcd_host_model

// ---- tb/display_mode_command_decoder_tb_top.sv ----
// Self-checking testbench of the display mode command decoder
`timescale 1ns/1ps
module display_mode_command_decoder_tb_top;
    logic       ref_clk, rst_n, writeStrobeN, readStrobeN, dataCommandSelect;
    logic [7:0] dataBus, cmd;
    logic       oscEnable, dcdcEnable, offsetChargeEnable, sleepOut, autoBlankActive, frameStart;
    logic       panelShowMemory, normalMode, partialNormalOff, idleSettingsApply, inversionOn, displayOn;
    logic       cmdIgnored, eNoff, eInv, eDisp, eSlp;
    int         fails = 0, n_tests = 0, nIgn = 0, blankLen, nFrm;
    integer     seed = 32'h33f3;
    logic [7:0] cmdTab [6] = '{8'h12, 8'h13, 8'h20, 8'h21, 8'h28, 8'h29};
    logic [7:0] corner [12] = '{8'h21, 8'h21, 8'h20, 8'h20, 8'h12, 8'h12, 8'h13, 8'h13,
                                8'h28, 8'h28, 8'h29, 8'h29};

    dmcd_mode_decoder #(.OSC_START_CYCLES(4), .DCDC_START_CYCLES(6), .OFFSET_CHARGE_CYCLES(8),
        .FRAME_CYCLES(20)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .writeStrobeN(writeStrobeN),
        .readStrobeN(readStrobeN), .dataCommandSelect(dataCommandSelect), .dataBus(dataBus),
        .oscEnable(oscEnable), .dcdcEnable(dcdcEnable), .offsetChargeEnable(offsetChargeEnable),
        .sleepOut(sleepOut), .autoBlankActive(autoBlankActive), .frameStart(frameStart),
        .panelShowMemory(panelShowMemory), .normalMode(normalMode), .partialNormalOff(partialNormalOff),
        .idleSettingsApply(idleSettingsApply), .inversionOn(inversionOn), .displayOn(displayOn),
        .cmdIgnored(cmdIgnored));

    dmcd_host_model host (.ref_clk(ref_clk), .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
        .dataCommandSelect(dataCommandSelect), .dataBus(dataBus));

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Count ignored-command pulses
    always @(posedge ref_clk) if (cmdIgnored === 1'b1) nIgn++;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // Expected no-op for a command in the present state
    function automatic logic is_noop(input logic [7:0] b);
        case (b)
            8'h12: return eNoff;
            8'h13: return !eNoff;
            8'h20: return !eInv;
            8'h21: return eInv;
            8'h28: return !eDisp;
            8'h29: return eDisp;
            8'h10: return !eSlp;
            8'h11: return eSlp;
            default: return 1'b0;
        endcase
    endfunction : is_noop

    // Expected state after an accepted command
    task automatic apply(input logic [7:0] b);
        case (b)
            8'h12: eNoff = 1'b1;
            8'h13: eNoff = 1'b0;
            8'h20: eInv = 1'b0;
            8'h21: eInv = 1'b1;
            8'h28: eDisp = 1'b0;
            8'h29: eDisp = 1'b1;
            8'h10: eSlp = 1'b0;
            8'h01: {eNoff, eInv, eDisp, eSlp} = 4'h0;
            default: ;
        endcase
    endtask : apply

    task automatic check_state();
        check(partialNormalOff, eNoff);
        check(normalMode, !eNoff);
        check(idleSettingsApply, eNoff);
        check(inversionOn, eInv);
        check(displayOn, eDisp);
        check(panelShowMemory, eSlp && eDisp);
        check(sleepOut, eSlp);
        check(oscEnable, eSlp);
    endtask : check_state

    task automatic do_cmd(input logic [7:0] b, input logic dc, input logic rd);
        int   ign0;
        logic noop;
        ign0 = nIgn;
        noop = is_noop(b) && !dc && rd;
        if (!dc && rd && !noop) apply(b);
        host.send(b, dc, rd);
        repeat (4) @(posedge ref_clk);
        #1;
        check(8'(nIgn - ign0), noop);
        check_state();
    endtask : do_cmd

    // Leave sleep and time the automatic blank frames
    task automatic wake();
        int n;
        host.send(8'h11, 1'b0, 1'b1);
        n = 0;
        while (autoBlankActive !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(offsetChargeEnable, 1'b1);
        check(panelShowMemory, 1'b0);
        blankLen = 0;
        nFrm = 0;
        while (autoBlankActive === 1'b1 && blankLen < 200) begin
            @(posedge ref_clk);
            #1;
            blankLen++;
            if (frameStart === 1'b1) nFrm++;
        end
        check(8'(blankLen), 8'h28);
        check(8'(nFrm), 8'h02);
        eSlp = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check_state();
    endtask : wake

    // Main sequence
    initial begin
        rst_n = 1'b0;
        {eNoff, eInv, eDisp, eSlp} = 4'h0;
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        @(posedge ref_clk);
        #1;
        check_state();
        do_cmd(8'h29, 1'b0, 1'b1); // Display on while still asleep
        wake();
        do_cmd(8'h11, 1'b0, 1'b1);
        foreach (corner[i]) do_cmd(corner[i], 1'b0, 1'b1);
        // Random commands among parameter writes and masked writes
        for (int i = 0; i < 60; i++) begin
            cmd = cmdTab[$unsigned($random(seed)) % 6];
            do_cmd(cmd, ($random(seed) & 7) == 0, ($random(seed) & 7) != 0);
        end
        do_cmd(8'h21, 1'b0, 1'b1);
        do_cmd(8'h10, 1'b0, 1'b1);
        do_cmd(8'h10, 1'b0, 1'b1);
        wake();
        do_cmd(8'h01, 1'b0, 1'b1);
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule : display_mode_command_decoder_tb_top

bind dmcd_mode_decoder dmcd_mode_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN), .dataCommandSelect(dataCommandSelect),
    .dataBus(dataBus), .oscEnable(oscEnable), .dcdcEnable(dcdcEnable),
    .offsetChargeEnable(offsetChargeEnable), .sleepOut(sleepOut), .autoBlankActive(autoBlankActive),
    .frameStart(frameStart), .panelShowMemory(panelShowMemory), .normalMode(normalMode),
    .partialNormalOff(partialNormalOff), .idleSettingsApply(idleSettingsApply),
    .inversionOn(inversionOn), .displayOn(displayOn), .cmdIgnored(cmdIgnored));
